/* File: hdl/ioxp_pkg.sv */
package ioxp_pkg;

    // Register pointer codes, two low pointer bits
    localparam logic [1:0] REG_PIN_INPUT = 2'h0;
    localparam logic [1:0] REG_OUT_LATCH = 2'h1;
    localparam logic [1:0] REG_INVERT = 2'h2;
    localparam logic [1:0] REG_DIRECTION = 2'h3;

    // Reset values of the writable registers
    localparam logic [7:0] RST_OUT_LATCH = 8'hFF;
    localparam logic [7:0] RST_INVERT = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [1:0] RST_POINTER = 2'h0;

    // Fixed upper part of the seven-bit bus address
    localparam logic [3:0] ADDR_FIXED = 4'h7;

    // Bit positions inside a byte on the wire
    localparam int RW_BIT = 0;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;

    // Spike filter: a spike shorter than this is rejected
    localparam int CLK_PERIOD_NS = 10;
    localparam int SPIKE_NS = 50;
    localparam int FILT_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_W = 4;

    // Bus engine states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_CMD = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100
    } ioxp_state_t;

endpackage : ioxp_pkg

/* File: hdl/ioxp_top.sv */
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Answer address 0111 plus three strap levels.
// - Last address bit: one reads, zero writes.
// - MSB first, one bit per SCL pulse.
// - Pull SDA low on ninth pulse after match.
// - Receiver acknowledges; transmitter releases SDA for ack.
// - Master NACK ends read; device releases SDA.
// - First write byte after address sets pointer.
// - Pointer low two bits select register.
// - Reads carry no command; use stored pointer.
// - Pointer persists across transactions until rewritten.
// - Input register returns live pin levels.
// - Writes to input register are discarded.
// - Latch drives output pins only; resets ones.
// - Latch reads return stored bits, not pins.
// - Invert bit flips reported level of input-direction pins only; resets zero.
// - Direction one means input; resets all inputs.
// - Write data bytes all land in register.
// - Reads repeat register; master NACKs last byte.
// - Capture pins at rising edge of ack pulse.
// - Input pin change asserts active-low interrupt.
// - Interrupt clears on return or input read.
// - Reset restores registers and bus engine.
module ioxp_top (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    input wire logic [2:0] ADDR_STRAP_I,
    input wire logic [7:0] IO_PINS_I,
    output logic [7:0] IO_PINS_O,
    output logic [7:0] IO_PINS_OE_N_O,
    output logic INT_O,
    output logic INT_OE_N_O
);
    import ioxp_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Declarations
    logic scl_bit; // SDA sampled at SCL rise, link domain
    logic scl_tog; // Flips on every SCL rise, link domain
    logic [2:0] tog_sync; // Toggle synchroniser plus edge stage
    logic bit_evt; // One rising SCL edge seen
    logic [1:0] line_raw; // Raw SCL (1) and SDA (0)
    logic [1:0] line_s1; // First synchroniser stage
    logic [1:0] line_s2; // Second synchroniser stage
    logic [1:0] line_f; // Filtered levels
    logic [1:0] line_fd; // Filtered levels, one cycle late
    logic [FILT_W-1:0] filt_cnt [2]; // Disagreement counters
    logic scl_f; // Filtered SCL
    logic start_det; // SDA falls while SCL high
    logic stop_det; // SDA rises while SCL high
    logic scl_fall; // Filtered SCL falling edge
    logic [7:0] pins_s1; // Pin synchroniser stage one
    logic [7:0] pins_s; // Pin levels in clock domain
    logic [2:0] strap_s1; // Strap synchroniser stage one
    logic [2:0] strap_s; // Strap levels in clock domain
    logic [2:0] strap_q; // Straps frozen at start
    ioxp_state_t state; // Bus engine state
    logic [3:0] bit_cnt; // Bits taken in this byte, 8 = ack slot
    logic [6:0] rx_shift; // Received bits so far
    logic [7:0] rx_byte; // Completed byte
    logic rd_mode; // Address asked for a read
    logic [1:0] pointer; // Register pointer
    logic [7:0] out_latch; // Output latch register
    logic [7:0] invert_mask; // Polarity inversion register
    logic [7:0] direction; // Direction register, 1 = input
    logic [7:0] in_cap; // Last captured pin levels
    logic [7:0] tx_byte; // Byte being sent to the master
    logic ack_due; // Device owes an ack in this slot
    logic byte_done; // Eighth bit just arrived
    logic ack_rise; // Ninth pulse rising edge
    logic int_pend; // An input differs from capture

    //////////////////////////////////////////////////////////////////////////
    // Helpers

    // Register read mux, shared by first and later read bytes
    function automatic logic [7:0] reg_read(input logic [1:0] sel,
                                            input logic [7:0] lvl);
        logic [7:0] val;
        val = 8'h00;
        case (sel)
            REG_PIN_INPUT: val = lvl ^ (invert_mask & direction);
            REG_OUT_LATCH: val = out_latch;
            REG_INVERT: val = invert_mask;
            REG_DIRECTION: val = direction;
            default: val = 8'h00;
        endcase
        return val;
    endfunction : reg_read

    //////////////////////////////////////////////////////////////////////////
    // Link domain: SCL itself clocks the data bit

    // Async reset here because SCL may never tick during reset
    always_ff @(posedge SCL_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scl_bit <= 1'b1;
            scl_tog <= 1'b0;
        end else begin
            scl_bit <= SDA_I;
            scl_tog <= ~scl_tog;
        end
    end

    // Toggle crossing; scl_bit is stable long before the toggle lands
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            tog_sync <= 3'h0;
        end else begin
            tog_sync <= {tog_sync[1:0], scl_tog};
        end
    end

    assign bit_evt = tog_sync[2] ^ tog_sync[1];

    //////////////////////////////////////////////////////////////////////////
    // Line synchronisers and spike filters

    assign line_raw = {SCL_I, SDA_I};

    generate
        for (genvar g = 0; g < 2; g++) begin : g_line
            // Two flops, then a level must persist to be believed
            always_ff @(posedge CLK_I) begin
                if (!RST_N_I) begin
                    line_s1[g] <= 1'b1;
                    line_s2[g] <= 1'b1;
                    line_f[g] <= 1'b1;
                    line_fd[g] <= 1'b1;
                    filt_cnt[g] <= '0;
                end else begin
                    line_s1[g] <= line_raw[g];
                    line_s2[g] <= line_s1[g];
                    line_fd[g] <= line_f[g];
                    if (line_s2[g] == line_f[g]) begin
                        filt_cnt[g] <= '0;
                    end else if (filt_cnt[g] == FILT_W'(FILT_CYC - 1)) begin
                        line_f[g] <= line_s2[g];
                        filt_cnt[g] <= '0;
                    end else begin
                        filt_cnt[g] <= filt_cnt[g] + FILT_W'(1);
                    end
                end
            end
        end
    endgenerate

    assign scl_f = line_f[1];
    assign start_det = scl_f & line_fd[1] & line_fd[0] & ~line_f[0];
    assign stop_det = scl_f & line_fd[1] & ~line_fd[0] & line_f[0];
    assign scl_fall = line_fd[1] & ~scl_f;

    // Pins keep sampling through reset, so the capture boots on live levels
    always_ff @(posedge CLK_I) begin
        pins_s1 <= IO_PINS_I;
        pins_s <= pins_s1;
    end

    // Straps come from outside: two flops each
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            strap_s1 <= 3'h0;
            strap_s <= 3'h0;
        end else begin
            strap_s1 <= ADDR_STRAP_I;
            strap_s <= strap_s1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Bus engine

    assign rx_byte = {rx_shift, scl_bit};
    assign byte_done = bit_evt && (bit_cnt == LAST_DATA_BIT) && (state != ST_IDLE);
    assign ack_rise = bit_evt && (bit_cnt == ACK_SLOT) && (state != ST_IDLE);
    // Only a matched address keeps ST_ADDR into the ack slot
    assign ack_due = (bit_cnt == ACK_SLOT) &&
                     (state == ST_ADDR || state == ST_CMD || state == ST_WDATA);

    // Strap levels are frozen for the whole transaction
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            strap_q <= 3'h0;
        end else if (start_det) begin
            strap_q <= strap_s;
        end
    end

    // State, bit count and shift register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            rx_shift <= 7'h00;
            rd_mode <= 1'b0;
        end else if (start_det) begin
            // Start or repeated start always reopens address phase
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
        end else if (bit_evt && state != ST_IDLE) begin
            if (bit_cnt == ACK_SLOT) begin
                bit_cnt <= 4'h0;
                case (state)
                    ST_ADDR: begin
                        state <= rd_mode ? ST_RDATA : ST_CMD;
                    end
                    ST_CMD: begin
                        state <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        // High on the ack slot is a NACK: stop sending
                        if (scl_bit) begin
                            state <= ST_IDLE;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
                rx_shift <= rx_byte[6:0];
                if (byte_done && state == ST_ADDR) begin
                    // Wrong address: drop out silently until next start
                    if (rx_byte[7:1] != {ADDR_FIXED, strap_q}) begin
                        state <= ST_IDLE;
                    end
                    rd_mode <= rx_byte[RW_BIT];
                end
            end
        end
    end

    // Command byte lands in the pointer; upper six bits are dropped
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pointer <= RST_POINTER;
        end else if (byte_done && state == ST_CMD) begin
            pointer <= rx_byte[1:0];
        end
    end

    // Data bytes; every byte goes to the same register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            out_latch <= RST_OUT_LATCH;
            invert_mask <= RST_INVERT;
            direction <= RST_DIRECTION;
        end else if (byte_done && state == ST_WDATA) begin
            case (pointer)
                REG_OUT_LATCH: out_latch <= rx_byte;
                REG_INVERT: invert_mask <= rx_byte;
                REG_DIRECTION: direction <= rx_byte;
                default: out_latch <= out_latch;
            endcase
        end
    end

    // Byte to send: loaded at each acked ninth rising edge of a read
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            tx_byte <= 8'hFF;
        end else if (ack_rise && !scl_bit &&
                     (state == ST_RDATA || (state == ST_ADDR && rd_mode))) begin
            tx_byte <= reg_read(pointer, pins_s);
        end
    end

    // Captured levels; refreshed only by reads of the input register
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            in_cap <= pins_s; // Boot without a false change
        end else if (ack_rise && pointer == REG_PIN_INPUT &&
                     (state == ST_RDATA || (state == ST_ADDR && rd_mode))) begin
            in_cap <= pins_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // SDA driver: changes just after SCL falls; a start or stop releases it

    // Hazard: driving while SCL is high would fake a start or stop
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            SDA_OE_N_O <= 1'b1;
        end else if (start_det || stop_det) begin
            SDA_OE_N_O <= 1'b1;
        end else if (scl_fall) begin
            if (ack_due) begin
                SDA_OE_N_O <= 1'b0;
            end else if (state == ST_RDATA && bit_cnt < ACK_SLOT) begin
                // Open drain: a one is a released line
                SDA_OE_N_O <= tx_byte[3'(LAST_DATA_BIT - bit_cnt)];
            end else begin
                SDA_OE_N_O <= 1'b1;
            end
        end
    end

    // Open-drain values are always low; only the enables move
    always_ff @(posedge CLK_I) begin
        SDA_O <= 1'b0;
        INT_O <= 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // Port pins and interrupt

    // Latch shows only where direction says output
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            IO_PINS_O <= RST_OUT_LATCH;
            IO_PINS_OE_N_O <= RST_DIRECTION;
        end else begin
            IO_PINS_O <= out_latch;
            IO_PINS_OE_N_O <= direction;
        end
    end

    // Output pins are masked out; a return to old level clears it
    assign int_pend = |((pins_s ^ in_cap) & direction);

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            INT_OE_N_O <= 1'b1;
        end else begin
            INT_OE_N_O <= ~int_pend;
        end
    end


    //////////////////////////////////////////////////////////////////////////
    // Checks

    a_reset_defaults: assert property (@(posedge CLK_I)
        !RST_N_I |=> (out_latch == 8'hFF && invert_mask == 8'h00 &&
                      direction == 8'hFF && state == ST_IDLE))
        else $error("registers not at defaults after reset");

    a_ack_drive: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (scl_fall && ack_due && !start_det && !stop_det) |=> !SDA_OE_N_O)
        else $error("owed ack not driven after SCL fall");

    a_addr_miss: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (byte_done && state == ST_ADDR && !start_det && !stop_det &&
         rx_byte[7:4] != ADDR_FIXED) |=> state == ST_IDLE)
        else $error("foreign address not ignored");

    a_cmd_store: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (byte_done && state == ST_CMD && !start_det && !stop_det)
        |=> pointer == $past(rx_byte[1:0]))
        else $error("command byte not stored");

    a_ptr_keep: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !(byte_done && state == ST_CMD) |=> $stable(pointer))
        else $error("pointer moved without command byte");

    a_input_discard: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (byte_done && state == ST_WDATA && pointer == REG_PIN_INPUT)
        |=> $stable(out_latch) && $stable(invert_mask) && $stable(direction))
        else $error("write to input register changed state");

    a_nack_end: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (ack_rise && state == ST_RDATA && scl_bit && !start_det && !stop_det)
        |=> state == ST_IDLE ##1 SDA_OE_N_O [*2])
        else $error("read not ended on NACK");

    a_read_capture: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (ack_rise && state == ST_RDATA && pointer == REG_PIN_INPUT)
        |=> in_cap == $past(pins_s) ##1 (INT_OE_N_O || int_pend))
        else $error("pins not captured at ack");

    a_int_output: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (|((pins_s ^ in_cap) & direction)) |=> !INT_OE_N_O)
        else $error("input change did not raise interrupt");

    a_out_pins: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        ##1 (IO_PINS_OE_N_O == $past(direction) && IO_PINS_O == $past(out_latch)))
        else $error("pin drivers disagree with registers");

endmodule : ioxp_top

/* File: tb/ioxp_i2c_master.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
// Bus master model; SCL idles high between frames
module ioxp_i2c_master (
    output logic scl_o, // Bus clock
    output logic sda_oe_n_o, // Low pulls SDA low
    input wire logic sda_i // Resolved SDA level
);
    // Each SCL phase spans three link ticks, so edges stay well apart
    localparam time TQ = 125ns;

    initial begin
        scl_o = 1'b1;
        sda_oe_n_o = 1'b1;
    end

    // One bit: SDA moves only while SCL is low, sampled one TQ into the 3*TQ high phase
    task automatic put_bit(input logic b, output logic s);
        #TQ;
        sda_oe_n_o = b;
        #(2*TQ);
        scl_o = 1'b1;
        #TQ;
        s = sda_i;
        #(2*TQ);
        scl_o = 1'b0;
    endtask : put_bit

    // Start or repeated start: SDA falls while SCL high
    task automatic start_cond();
        #TQ;
        sda_oe_n_o = 1'b1;
        #(2*TQ);
        scl_o = 1'b1;
        #(2*TQ);
        sda_oe_n_o = 1'b0;
        #(2*TQ);
        scl_o = 1'b0;
    endtask : start_cond

    // Stop: SDA rises while SCL high, then bus free time
    task automatic stop_cond();
        #TQ;
        sda_oe_n_o = 1'b0;
        #(2*TQ);
        scl_o = 1'b1;
        #(2*TQ);
        sda_oe_n_o = 1'b1;
        #(4*TQ);
    endtask : stop_cond

    // Byte out MSB first, SDA released for the ack slot
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte

    // Byte in; ack all but the last, which is left high
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(last, s);
    endtask : recv_byte
endmodule : ioxp_i2c_master

/* File: tb/ioxp_top_tb.sv */
`timescale 1ns/1ps

`define CHK(got, exp) chk(8'(got), 8'(exp))

module ioxp_top_tb;
    import ioxp_pkg::*;
    logic clk, rst_n; // System clock and reset
    logic scl, m_sda_oe_n, sda, sda_o, sda_oe_n; // Link wires
    logic [2:0] straps; // Held steady within transactions
    logic [7:0] ext_pins, pins, io_out, io_oe_n; // Pin side
    logic int_oe_n, int_o; // Interrupt enable (low asserts) and driven value
    logic [7:0] d0, d1; // Read results
    int miscompares, cmp_count;

    // Open-drain SDA with pull-up; driven pins win over outside levels
    assign sda = m_sda_oe_n & (sda_oe_n | sda_o);
    assign pins = (io_oe_n & ext_pins) | (~io_oe_n & io_out);

    always #5 clk = ~clk;

    ioxp_top DUT (.CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE_N_O(sda_oe_n), .ADDR_STRAP_I(straps), .IO_PINS_I(pins), .IO_PINS_O(io_out),
        .IO_PINS_OE_N_O(io_oe_n), .INT_O(int_o), .INT_OE_N_O(int_oe_n));

    ioxp_i2c_master m (.scl_o(scl), .sda_oe_n_o(m_sda_oe_n), .sda_i(sda));

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("TB: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // Pointer write, then any number of data bytes
    task automatic reg_write(input logic [1:0] p, input int n, input logic [7:0] a, b);
        logic ack;
        m.start_cond();
        m.send_byte({ADDR_FIXED, straps, 1'b0}, ack);
        `CHK(ack, 1'b1);
        m.send_byte({6'h00, p}, ack);
        `CHK(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.send_byte(i == 0 ? a : b, ack);
            `CHK(ack, 1'b1);
        end
        m.stop_cond();
    endtask : reg_write

    // Optional pointer write, repeated start, one or two bytes read back
    task automatic reg_read(input logic set, input logic [1:0] p, input int n);
        logic ack;
        if (set) begin
            m.start_cond();
            m.send_byte({ADDR_FIXED, straps, 1'b0}, ack);
            `CHK(ack, 1'b1);
            m.send_byte({6'h00, p}, ack);
            `CHK(ack, 1'b1);
        end
        m.start_cond();
        m.send_byte({ADDR_FIXED, straps, 1'b1}, ack);
        `CHK(ack, 1'b1);
        m.recv_byte(n == 1, d0);
        d1 = 8'h00;
        if (n > 1) begin
            m.recv_byte(1'b1, d1);
        end
        m.stop_cond();
    endtask : reg_read

    // Bounded wait for the interrupt line level
    task automatic wait_int(input logic lvl);
        int n;
        n = 0;
        while (int_oe_n !== lvl && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) begin
            miscompares++;
            summarize();
        end
    endtask : wait_int

    ////////////////////////////////////////////////////////////
    // Run cut short if anything hangs
    initial begin
        #950us;
        miscompares++;
        summarize();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b1; // Dropped below so the link flops see a real falling edge
        straps = 3'h5;
        ext_pins = 8'hC3;
        miscompares = 0;
        cmp_count = 0;
        @(negedge clk) rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        // Reset state at pins and in registers
        `CHK(io_oe_n, RST_DIRECTION);
        `CHK(io_out, RST_OUT_LATCH);
        `CHK(int_oe_n, 1'b1);
        for (int i = 1; i < 4; i++) begin
            reg_read(1'b1, i[1:0], 1);
            `CHK(d0, i == 1 ? RST_OUT_LATCH : i == 2 ? RST_INVERT : RST_DIRECTION);
        end
        $display("TEST reset values done");
        // Only the strapped address is acknowledged
        for (int a = 0; a < 8; a++) begin
            logic ack;
            m.start_cond();
            m.send_byte({ADDR_FIXED, a[2:0], 1'b0}, ack);
            m.stop_cond();
            `CHK(ack, a[2:0] == straps);
        end
        // Foreign upper address bits are never acknowledged
        m.start_cond();
        m.send_byte({4'h3, straps, 1'b0}, d0[0]);
        m.stop_cond();
        `CHK(d0[0], 1'b0);
        $display("TEST addressing done");
        // Upper nibble driven, lower nibble input; both bytes land, last wins
        reg_write(REG_DIRECTION, 2, 8'h33, 8'h0F);
        reg_write(REG_OUT_LATCH, 2, 8'h12, 8'h5A);
        `CHK(io_oe_n, 8'h0F);
        `CHK(io_out, 8'h5A);
        reg_read(1'b1, REG_OUT_LATCH, 1);
        `CHK(d0, 8'h5A);
        reg_read(1'b1, REG_DIRECTION, 1);
        `CHK(d0, 8'h0F);
        reg_read(1'b1, REG_PIN_INPUT, 1);
        `CHK(d0, 8'h53);
        $display("TEST write and pins done");
        // Inversion on inputs only; pointer persists over reads
        reg_write(REG_INVERT, 1, 8'hFF, 8'h00);
        reg_read(1'b1, REG_PIN_INPUT, 2);
        `CHK(d0, 8'h5C);
        `CHK(d1, 8'h5C);
        reg_read(1'b0, REG_PIN_INPUT, 1);
        `CHK(d0, 8'h5C);
        $display("TEST invert and pointer done");
        // Input change raises, return clears; driven pin never raises
        @(negedge clk) ext_pins = 8'hC2;
        wait_int(1'b0);
        `CHK(int_oe_n, 1'b0);
        `CHK(int_o, 1'b0);
        @(negedge clk) ext_pins = 8'hC3;
        wait_int(1'b1);
        `CHK(int_oe_n, 1'b1);
        @(negedge clk) ext_pins = 8'h43;
        repeat (30) @(negedge clk);
        `CHK(int_oe_n, 1'b1);
        @(negedge clk) ext_pins = 8'h41;
        wait_int(1'b0);
        reg_read(1'b0, REG_PIN_INPUT, 1);
        `CHK(d0, 8'h5E);
        `CHK(int_oe_n, 1'b1);
        $display("TEST interrupt done");
        // Data written with pointer zero is dropped
        reg_write(REG_PIN_INPUT, 1, 8'h00, 8'h00);
        for (int i = 1; i < 4; i++) begin
            reg_read(1'b1, i[1:0], 1);
            `CHK(d0, i == 1 ? 8'h5A : i == 2 ? 8'hFF : 8'h0F);
        end
        `CHK(io_out, 8'h5A);
        $display("TEST input write discard done");
        // Second reset in mid-run, with new straps
        @(negedge clk) rst_n = 1'b0;
        straps = 3'h2;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(io_oe_n, RST_DIRECTION);
        reg_read(1'b1, REG_OUT_LATCH, 1);
        `CHK(d0, RST_OUT_LATCH);
        $display("TEST second reset done");
        summarize();
    end
endmodule : ioxp_top_tb
